// ### rtl/udi_defs.svh
// Purpose: constants for the device event flag block
// Assumes: 40 MHz clk
// Notes: offsets are byte addresses on apb
`ifndef UDI_DEFS_SVH
`define UDI_DEFS_SVH
`define UDI_OFF_FLAGS 12'h218
`define UDI_OFF_SPEED 12'h21C
`define UDI_FLAGS_RESET 32'h0000_0000
`define UDI_VALID_MASK 32'h03FF_FDFF
`define UDI_BIT_EP_BASE 10
`define UDI_BIT_SETUP 8
`define UDI_BIT_VBUS 7
`define UDI_BIT_DMA 6
`define UDI_BIT_HS 5
`define UDI_BIT_RESUME 4
`define UDI_BIT_SUSP 3
`define UDI_BIT_PSEUDO 2
`define UDI_BIT_SOF 1
`define UDI_BIT_BUS_RST 0
`define UDI_CLK_HZ 40000000
`define UDI_FS_PERIOD_US 1000
`define UDI_HS_PERIOD_NS 125000
`define UDI_FS_CYCLES ((`UDI_FS_PERIOD_US * (`UDI_CLK_HZ / 1000000)))
`define UDI_HS_CYCLES ((`UDI_HS_PERIOD_NS / 1000) * (`UDI_CLK_HZ / 1000000))
`endif

// ### rtl/udi_pkg.sv
// Purpose: types for the device event flag block
// Assumes: nothing
// Notes: link state of the bus
package udi_pkg;
    typedef enum logic [1:0] {UDI_ACTIVE, UDI_SUSPENDED} udi_link_t;
endpackage

// ### rtl/udi_event_flags.sv
// Purpose: usb device event flag register with apb slave and interrupt
// Assumes: event inputs synchronous to clk, one-cycle pulses or levels as named
// Notes: flags at 0x218 write one to clear, speed status at 0x21C read only
//
// Overview of operation
// - endpoint n rx sets bit 10+2n, tx sets bit 11+2n
// - setup token on endpoint 0 sets bit 8
// - rising edge of bus supply sense sets bit 7
// - any change of dma reason register sets bit 6
// - switch from full speed to high speed sets bit 5
// - dropping into full-speed suspend never sets bit 5
// - suspended to active bus state sets bit 4
// - active to suspended bus state sets bit 3
// - internal pseudo frame marker sets bit 2
// - marker free-running: 1 ms full speed, 125 us high speed
// - received frame start token sets bit 1
// - detected bus reset sets bit 0
// - interrupt high while any unmasked flag is set
// - writing one clears that flag only
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "udi_defs.svh"
module udi_event_flags (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] endpoint_rx_flag,
    input wire logic [7:0] endpoint_tx_flag,
    input wire logic control_setup_flag,
    input wire logic vbus_sense,
    input wire logic [31:0] dma_reason,
    input wire logic high_speed,
    input wire logic bus_suspended,
    input wire logic frame_token,
    input wire logic bus_reset_flag,
    input wire logic [31:0] irq_mask,
    output logic irq
);
    // =====================================================
    // bus decode
    logic [31:0] device_event_flags;
    logic [31:0] next_flags;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic wr_access;
    logic rd_access;
    logic vbus_d;
    logic hs_d;
    logic [31:0] dma_d;
    udi_pkg::udi_link_t link_state;
    logic [15:0] pf_cnt;
    logic pf_tick;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !hit(paddr, `UDI_OFF_FLAGS) &&
                     !(hit(paddr, `UDI_OFF_SPEED) && !pwrite);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (rd_access && hit(paddr, `UDI_OFF_FLAGS))
            prdata <= device_event_flags;
        else if (rd_access && hit(paddr, `UDI_OFF_SPEED))
            prdata <= {30'h0000_0000, bus_suspended, high_speed};
        else if (rd_access)
            prdata <= 32'h0000_0000;
    end

    // =====================================================
    // edge history
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vbus_d <= 1'b0;
            hs_d <= 1'b0;
            dma_d <= 32'h0000_0000;
        end
        else
        begin
            vbus_d <= vbus_sense;
            hs_d <= high_speed;
            dma_d <= dma_reason;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            link_state <= udi_pkg::UDI_ACTIVE;
        else
        begin
            case (link_state)
                udi_pkg::UDI_ACTIVE:
                    if (bus_suspended)
                        link_state <= udi_pkg::UDI_SUSPENDED;
                udi_pkg::UDI_SUSPENDED:
                    if (!bus_suspended)
                        link_state <= udi_pkg::UDI_ACTIVE;
                default:
                    link_state <= udi_pkg::UDI_ACTIVE;
            endcase
        end
    end

    // =====================================================
    // pseudo frame marker
    // free-running period
    // not aligned to frame tokens on purpose; restarts only on reset and on its own tick
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pf_cnt <= 16'h0000;
        else if (pf_tick)
            pf_cnt <= 16'h0000;
        else
            pf_cnt <= pf_cnt + 16'h0001;
    end
    // >= in both modes: a speed switch past the mark must not wait for a wrap
    assign pf_tick = high_speed ? (pf_cnt >= 16'(`UDI_HS_CYCLES - 1))
                                : (pf_cnt >= 16'(`UDI_FS_CYCLES - 1));

    // =====================================================
    // flag set and clear
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ep
            assign set_vec[`UDI_BIT_EP_BASE + 2 * gi] = endpoint_rx_flag[gi];
            assign set_vec[`UDI_BIT_EP_BASE + 2 * gi + 1] = endpoint_tx_flag[gi];
        end
    endgenerate
    assign set_vec[31:26] = 6'h00;
    assign set_vec[9] = 1'b0;
    assign set_vec[`UDI_BIT_SETUP] = control_setup_flag;
    assign set_vec[`UDI_BIT_VBUS] = vbus_sense && !vbus_d;
    assign set_vec[`UDI_BIT_DMA] = (dma_reason != dma_d);
    assign set_vec[`UDI_BIT_HS] = high_speed && !hs_d;
    assign set_vec[`UDI_BIT_RESUME] = (link_state == udi_pkg::UDI_SUSPENDED) && !bus_suspended;
    assign set_vec[`UDI_BIT_SUSP] = (link_state == udi_pkg::UDI_ACTIVE) && bus_suspended;
    assign set_vec[`UDI_BIT_PSEUDO] = pf_tick;
    assign set_vec[`UDI_BIT_SOF] = frame_token;
    assign set_vec[`UDI_BIT_BUS_RST] = bus_reset_flag;

    assign clr_vec = (wr_access && hit(paddr, `UDI_OFF_FLAGS)) ? pwdata : 32'h0000_0000;
    // set wins over clear so no event is lost
    assign next_flags = ((device_event_flags & ~clr_vec) | set_vec) & `UDI_VALID_MASK;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            device_event_flags <= `UDI_FLAGS_RESET;
        else
            device_event_flags <= next_flags;
    end

    assign irq = |(device_event_flags & irq_mask);

    // =====================================================
    // checks
    // reserved bits zero
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (device_event_flags & ~`UDI_VALID_MASK) == 32'h0000_0000)
        else $error("reserved flag bit set");
    a_vbus_sets: assert property (@(posedge clk) disable iff (!resetn)
        (vbus_sense && !vbus_d) |=> device_event_flags[`UDI_BIT_VBUS])
        else $error("vbus rise not flagged");
    a_ep_rx_sets: assert property (@(posedge clk) disable iff (!resetn)
        endpoint_rx_flag[3] |=> device_event_flags[16])
        else $error("endpoint rx flag lost");
    a_setup_sets: assert property (@(posedge clk) disable iff (!resetn)
        control_setup_flag |=> device_event_flags[`UDI_BIT_SETUP])
        else $error("setup flag lost");
    a_dma_sets: assert property (@(posedge clk) disable iff (!resetn)
        (dma_reason != $past(dma_reason)) |=> device_event_flags[`UDI_BIT_DMA])
        else $error("dma change not flagged");
    a_hs_cause: assert property (@(posedge clk) disable iff (!resetn)
        $rose(device_event_flags[`UDI_BIT_HS]) |-> $past(high_speed && !hs_d))
        else $error("speed flag without speed rise");
    a_susp_sets: assert property (@(posedge clk) disable iff (!resetn)
        $rose(bus_suspended) |=> device_event_flags[`UDI_BIT_SUSP])
        else $error("suspend not flagged");
    a_resume_sets: assert property (@(posedge clk) disable iff (!resetn)
        $fell(bus_suspended) |=> device_event_flags[`UDI_BIT_RESUME])
        else $error("resume not flagged");
    a_clear_one: assert property (@(posedge clk) disable iff (!resetn)
        (wr_access && hit(paddr, `UDI_OFF_FLAGS) && pwdata[`UDI_BIT_SOF] && !frame_token)
        |=> !device_event_flags[`UDI_BIT_SOF])
        else $error("frame flag not cleared");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        irq == ((device_event_flags & irq_mask) != 32'h0000_0000))
        else $error("irq level wrong");
    a_pseudo_gap: assert property (@(posedge clk) disable iff (!resetn)
        (pf_tick && high_speed) |=> (!pf_tick)[*8])
        else $error("pseudo frame too soon");
    a_bus_rst_sets: assert property (@(posedge clk) disable iff (!resetn)
        bus_reset_flag |=> device_event_flags[`UDI_BIT_BUS_RST])
        else $error("bus reset not flagged");

    // =====================================================
    // multi-step checks
    // bus goes from active to suspended
    sequence s_enter_suspend;
        !bus_suspended ##1 bus_suspended;
    endsequence
    // bus goes from suspended back to active
    sequence s_leave_suspend;
        bus_suspended ##1 !bus_suspended;
    endsequence
    // marker fires, then the flag stands
    sequence s_pseudo_fire;
        pf_tick ##1 device_event_flags[`UDI_BIT_PSEUDO];
    endsequence

    a_susp_seq: assert property (@(posedge clk) disable iff (!resetn)
        s_enter_suspend |=> device_event_flags[`UDI_BIT_SUSP])
        else $error("suspend entry not flagged");
    a_resume_seq: assert property (@(posedge clk) disable iff (!resetn)
        s_leave_suspend |=> device_event_flags[`UDI_BIT_RESUME])
        else $error("resume entry not flagged");
    a_pseudo_holds: assert property (@(posedge clk) disable iff (!resetn)
        (s_pseudo_fire ##0 !(wr_access && hit(paddr, `UDI_OFF_FLAGS)
            && pwdata[`UDI_BIT_PSEUDO])) |=> device_event_flags[`UDI_BIT_PSEUDO])
        else $error("pseudo frame flag dropped");
    a_pseudo_irq: assert property (@(posedge clk) disable iff (!resetn)
        s_pseudo_fire |-> (irq || !irq_mask[`UDI_BIT_PSEUDO]))
        else $error("pseudo frame irq missing");

    // =====================================================
    // single-step checks
    // marker sets flag
    a_pseudo_sets: assert property (@(posedge clk) disable iff (!resetn)
        pf_tick |=> device_event_flags[`UDI_BIT_PSEUDO])
        else $error("pseudo frame not flagged");
    a_frame_sets: assert property (@(posedge clk) disable iff (!resetn)
        frame_token |=> device_event_flags[`UDI_BIT_SOF])
        else $error("frame token not flagged");
    a_hs_sets: assert property (@(posedge clk) disable iff (!resetn)
        (high_speed && !hs_d) |=> device_event_flags[`UDI_BIT_HS])
        else $error("speed rise not flagged");
    a_hs_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (!high_speed && !device_event_flags[`UDI_BIT_HS]) |=> !device_event_flags[`UDI_BIT_HS])
        else $error("speed flag at full speed");
    a_ep_tx_sets: assert property (@(posedge clk) disable iff (!resetn)
        endpoint_tx_flag[7] |=> device_event_flags[25])
        else $error("endpoint tx flag lost");
    a_clear_keeps: assert property (@(posedge clk) disable iff (!resetn)
        (wr_access && hit(paddr, `UDI_OFF_FLAGS) && !pwdata[11] && device_event_flags[11])
        |=> device_event_flags[11])
        else $error("flag cleared without a one");
    a_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        (frame_token && wr_access && hit(paddr, `UDI_OFF_FLAGS))
        |=> device_event_flags[`UDI_BIT_SOF])
        else $error("event lost to clear");
    a_vbus_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (!(vbus_sense && !vbus_d) && !device_event_flags[`UDI_BIT_VBUS])
        |=> !device_event_flags[`UDI_BIT_VBUS])
        else $error("vbus flag without rise");
    a_dma_quiet: assert property (@(posedge clk) disable iff (!resetn)
        ((dma_reason == dma_d) && !device_event_flags[`UDI_BIT_DMA])
        |=> !device_event_flags[`UDI_BIT_DMA])
        else $error("dma flag without change");
    a_slverr_map: assert property (@(posedge clk) disable iff (!resetn)
        (psel && penable && !hit(paddr, `UDI_OFF_FLAGS) && !hit(paddr, `UDI_OFF_SPEED))
        |-> pslverr)
        else $error("unmapped access not refused");

    // =====================================================
    // marker timing checks
    // count within period
    a_pseudo_bound: assert property (@(posedge clk) disable iff (!resetn)
        pf_cnt <= 16'(`UDI_FS_CYCLES - 1))
        else $error("pseudo frame count overrun");
    a_pseudo_fs_gap: assert property (@(posedge clk) disable iff (!resetn)
        (pf_tick && !high_speed) |=> (!pf_tick)[*8])
        else $error("full speed pseudo frame too soon");
endmodule

// ### dv/udi_host_model.sv
// Purpose: bus-side event source
// Assumes: cmd lasts one clk
// Notes: levels hold until a later cmd
`timescale 1ns/100ps
module udi_host_model (
    input wire logic clk,
    input wire logic [3:0] cmd,
    input wire logic [31:0] dma_next,
    output logic setup,
    output logic frame,
    output logic bus_rst,
    output logic vbus,
    output logic hs,
    output logic susp,
    output logic [31:0] dma
);
    // ==========
    // bus events
    initial {setup, frame, bus_rst, vbus, hs, susp, dma} = '0;
    always @(posedge clk)
    begin
        setup <= cmd == 4'h1;
        frame <= cmd == 4'h2;
        bus_rst <= cmd == 4'h3;
        case (cmd)
            4'h4: vbus <= 1'b1;
            4'h5: vbus <= 1'b0;
            4'h6: hs <= 1'b1;
            4'h7: {hs, susp} <= 2'b01;
            4'h8: susp <= 1'b0;
            4'h9: dma <= dma_next;
            default: ;
        endcase
    end
endmodule

// ### dv/tb_top.sv
// Purpose: self-checking bench for the event flags
// Assumes: zero wait apb
// Notes: reads checked by a monitor from a queue
`timescale 1ns/100ps
`include "udi_defs.svh"
module tb_top;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
    logic setup, frame, bus_rst, vbus, hs, susp, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, irq_mask, dma_next, dma, rnd;
    logic [31:0] q[$];
    logic [31:0] expv[1:9];
    logic [7:0] ep_rx, ep_tx;
    logic [3:0] cmd;
    int bad_count, n_checks;
    realtime t1;
    udi_event_flags dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .endpoint_rx_flag(ep_rx), .endpoint_tx_flag(ep_tx),
        .control_setup_flag(setup), .vbus_sense(vbus), .dma_reason(dma), .high_speed(hs),
        .bus_suspended(susp), .frame_token(frame), .bus_reset_flag(bus_rst),
        .irq_mask(irq_mask), .irq(irq));
    udi_host_model host (.clk(clk), .cmd(cmd), .dma_next(dma_next), .setup(setup),
        .frame(frame), .bus_rst(bus_rst), .vbus(vbus), .hs(hs), .susp(susp), .dma(dma));
    // ==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: psel never set twice in one step, and the write has landed
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic evt(input logic [3:0] k);
        cmd <= k;
        @(posedge clk);
        cmd <= 4'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        if (psel && penable && !pwrite && pready)
            chk(prdata, q.pop_front());
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        results();
    end
    // ==========
    // tests
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ep_rx, ep_tx, cmd, dma_next} = '0;
        irq_mask = 32'hFFFF_FFFF;
        rnd = 32'hEC26_9EC0;
        expv = '{32'h100, 32'h2, 32'h1, 32'h80, 32'h0, 32'h20, 32'h8, 32'h10, 32'h40};
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(`UDI_OFF_FLAGS, `UDI_FLAGS_RESET);
        rd(12'h100, 32'h0);
        chk(last_err, 32'h1);
        apb(1'b1, `UDI_OFF_SPEED, 32'hFFFF_FFFF);
        chk(last_err, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            {ep_rx, ep_tx} <= {2{8'h01 << i}};
            @(posedge clk);
            {ep_rx, ep_tx} <= 16'h0;
            repeat (2) @(posedge clk);
            rd(`UDI_OFF_FLAGS, 32'h3 << (10 + 2 * i));
            apb(1'b1, `UDI_OFF_FLAGS, 32'h1 << (10 + 2 * i));
            rd(`UDI_OFF_FLAGS, 32'h2 << (10 + 2 * i));
            apb(1'b1, `UDI_OFF_FLAGS, 32'hFFFF_FFFF);
        end
        for (int k = 1; k <= 9; k++)
        begin
            rnd = lfsr(rnd);
            dma_next <= rnd | 32'h1;
            evt(k[3:0]);
            rd(`UDI_OFF_FLAGS, expv[k]);
            chk(irq, expv[k] != 0);
            if (k == 9)
            begin
                dma_next <= 32'h0;
                evt(4'h9);
            end
            apb(1'b1, `UDI_OFF_FLAGS, expv[k]);
            rd(`UDI_OFF_FLAGS, 32'h0);
        end
        $display("test events done");
        irq_mask <= 32'h0;
        evt(4'h2);
        chk(irq, 32'h0);
        irq_mask <= 32'h2;
        @(posedge clk);
        chk(irq, 32'h1);
        evt(4'h6);
        rd(`UDI_OFF_SPEED, 32'h1);
        chk(last_err, 32'h0);
        apb(1'b1, `UDI_OFF_FLAGS, 32'hFFFF_FFFF);
        irq_mask <= 32'h4;
        // sampled on the falling edge so both marks share one phase
        while (irq !== 1'b1)
            @(negedge clk);
        t1 = $realtime;
        @(posedge clk);
        apb(1'b1, `UDI_OFF_FLAGS, 32'h4);
        while (irq !== 1'b1)
            @(negedge clk);
        chk(int'(($realtime - t1) / 25.0), 32'd5000);
        @(posedge clk);
        rd(`UDI_OFF_FLAGS, 32'h4);
        $display("test frame done");
        results();
    end
endmodule
